/* File: hdl/bcu_bridge_control.sv */
`timescale 1ns/1ps
`include "bcu_regs.svh"

module bcu_bridge_control
   import bcu_pkg::*;
#(
   parameter int unsigned TMO_LONG_CLKS = `BCU_TMO_LONG_CLKS
) (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   // configuration access from the primary side
   input wire logic cfg_wr_i,
   input wire logic cfg_rd_i,
   input wire logic [7:0] cfg_addr_i,
   input wire logic [3:0] cfg_byte_en_n_i,
   input wire logic [31:0] cfg_wdata_i,
   output logic [31:0] cfg_rdata_o,
   // primary command register bits
   input wire logic cmd_io_space_en_i,
   input wire logic cmd_mem_space_en_i,
   input wire logic cmd_system_error_forward_enable_i,
   // delayed transaction queue
   input wire logic dt_head_valid_i,
   input wire logic dt_retry_i,
   output logic dt_discard_o,
   // master abort seen on a bridge-initiated cycle
   input wire logic ma_event_i,
   input wire logic ma_posted_i,
   input wire logic ma_read_i,
   output logic ma_trdy_o,
   output logic ma_target_abort_o,
   output logic [31:0] ma_rdata_o,
   // primary address decode
   input wire logic [31:0] pri_addr_i,
   input wire logic pri_io_i,
   input wire logic pri_mem_i,
   input wire logic pri_io_win_hit_i,
   input wire logic pri_mem_win_hit_i,
   output logic pri_claim_o,
   // secondary address decode
   input wire logic [31:0] sec_addr_i,
   input wire logic sec_io_i,
   input wire logic sec_mem_i,
   output logic sec_claim_o,
   // secondary parity events
   input wire logic sec_data_perr_i,
   input wire logic sec_addr_perr_i,
   input wire logic sec_bridge_master_i,
   output logic data_parity_reported_set_o,
   // pins
   input wire logic secondary_system_error_pin_n_i,
   output logic primary_system_error_pin_o,
   output logic primary_system_error_pin_oe_n_o,
   output logic secondary_parity_error_pin_o,
   output logic secondary_parity_error_pin_oe_n_o,
   output logic sec_bus_reset_n_o,
   output logic sec_logic_reset_o
);

   logic [1:0] rst_sync_q;
   logic rst_n;
   logic [31:0] ctrl_q;
   logic [31:0] wmask;
   logic cfg_hit;
   logic [31:0] rdata_q;
   logic [1:0] serr_pin_sync_q;
   logic sec_serr_seen;
   logic serr_q;
   logic perr_q;
   logic dpr_q;
   logic ma_trdy_q;
   logic ma_tabort_q;
   logic [31:0] ma_rdata_q;
   logic f_pri_tmo, f_sec_reset, f_ma_mode, f_vga, f_isa, f_serr, f_perr;
   logic vga_ok, pri_vga_mem, pri_vga_io, pri_alias;
   logic sec_vga_mem, sec_vga_io, sec_alias;

   // reset release through two flops
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // field views of the control word
   assign f_pri_tmo = ctrl_q[`BCU_BIT_PRI_TMO];
   assign f_sec_reset = ctrl_q[`BCU_BIT_SEC_RESET];
   assign f_ma_mode = ctrl_q[`BCU_BIT_MA_MODE];
   assign f_vga = ctrl_q[`BCU_BIT_VGA];
   assign f_isa = ctrl_q[`BCU_BIT_ISA];
   assign f_serr = ctrl_q[`BCU_BIT_SERR_FWD];
   assign f_perr = ctrl_q[`BCU_BIT_PERR_RESP];

   // write mask from enabled upper byte lanes
   assign cfg_hit = (cfg_addr_i == `BCU_OFS_BRIDGE_CTRL);
   assign wmask = `BCU_CTRL_WMASK
      & {{8{!cfg_byte_en_n_i[`BCU_LANE_HI]}},
         {8{!cfg_byte_en_n_i[`BCU_LANE_MID]}}, 16'h0000};

   // control word; fast back-to-back and reserved bits never stored
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= `BCU_CTRL_RESET;
      end else if (cfg_wr_i && cfg_hit) begin
         ctrl_q <= (ctrl_q & ~wmask) | (cfg_wdata_i & wmask);
      end
   end

   // registered read answer, zero off the mapped offset
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 32'h0000_0000;
      end else if (cfg_rd_i) begin
         if (cfg_hit) begin
            rdata_q <= ctrl_q;
         end else begin
            rdata_q <= 32'h0000_0000;
         end
      end
   end
   assign cfg_rdata_o = rdata_q;

   // secondary reset pin straight from the control bit
   assign sec_bus_reset_n_o = !f_sec_reset;
   assign sec_logic_reset_o = f_sec_reset || !rst_n;

   // delayed transaction retry timer, cleared with the buffers
   bcu_retry_timer #(
      .LONG_CLKS(TMO_LONG_CLKS),
      .SHORT_CLKS(`BCU_TMO_SHORT_CLKS),
      .CW(16)
   ) u_retry_timer (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n),
      .clear_i(f_sec_reset),
      .short_sel_i(f_pri_tmo),
      .head_valid_i(dt_head_valid_i),
      .retry_i(dt_retry_i),
      .discard_o(dt_discard_o)
   );

   // master abort completion per abort mode
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ma_trdy_q <= 1'b0;
         ma_tabort_q <= 1'b0;
         ma_rdata_q <= 32'h0000_0000;
      end else begin
         ma_trdy_q <= ma_event_i && !ma_posted_i && !f_ma_mode;
         ma_tabort_q <= ma_event_i && !ma_posted_i && f_ma_mode;
         if (ma_event_i && ma_read_i && !f_ma_mode) begin
            ma_rdata_q <= `BCU_MA_READ_DATA;
         end else if (ma_event_i) begin
            ma_rdata_q <= 32'h0000_0000;
         end
      end
   end
   assign ma_trdy_o = ma_trdy_q;
   assign ma_target_abort_o = ma_tabort_q;
   assign ma_rdata_o = ma_rdata_q;

   // secondary system error pin into the clock domain
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         serr_pin_sync_q <= 2'b11;
      end else begin
         serr_pin_sync_q <= {serr_pin_sync_q[0],
                             secondary_system_error_pin_n_i};
      end
   end
   assign sec_serr_seen = !serr_pin_sync_q[1];

   // primary system error sources
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         serr_q <= 1'b0;
      end else begin
         serr_q <= cmd_system_error_forward_enable_i && (
            (ma_event_i && ma_posted_i && f_ma_mode) ||
            (sec_serr_seen && f_serr) ||
            (sec_addr_perr_i && f_perr));
      end
   end
   // open-drain: low level, enable low while asserting
   assign primary_system_error_pin_o = 1'b0;
   assign primary_system_error_pin_oe_n_o = !serr_q;

   // secondary data parity response
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         perr_q <= 1'b0;
         dpr_q <= 1'b0;
      end else begin
         perr_q <= sec_data_perr_i && f_perr;
         dpr_q <= sec_data_perr_i && f_perr && sec_bridge_master_i;
      end
   end
   assign secondary_parity_error_pin_o = 1'b0;
   assign secondary_parity_error_pin_oe_n_o = !perr_q;
   assign data_parity_reported_set_o = dpr_q;

   // VGA forwarding needs both space enables
   assign vga_ok = f_vga && cmd_io_space_en_i && cmd_mem_space_en_i;

   // primary decode of legacy ranges; bits 15:10 ignored for I/O
   assign pri_vga_mem = pri_mem_i && (pri_addr_i >= `BCU_VGA_MEM_LO)
      && (pri_addr_i <= `BCU_VGA_MEM_HI);
   assign pri_vga_io = pri_io_i
      && (pri_addr_i[31:16] == `BCU_IO_64K_UPPER)
      && (((pri_addr_i[9:0] >= `BCU_VGA_IO_A_LO)
           && (pri_addr_i[9:0] <= `BCU_VGA_IO_A_HI))
          || ((pri_addr_i[9:0] >= `BCU_VGA_IO_B_LO)
              && (pri_addr_i[9:0] <= `BCU_VGA_IO_B_HI)));
   assign pri_alias = (pri_addr_i[31:16] == `BCU_IO_64K_UPPER)
      && (pri_addr_i[9:0] >= `BCU_ISA_ALIAS_LO);

   // downstream claim on the primary bus
   always_comb begin
      pri_claim_o = 1'b0;
      if (vga_ok && (pri_vga_mem || pri_vga_io)) begin
         pri_claim_o = 1'b1;
      end else if (pri_io_i && pri_io_win_hit_i) begin
         pri_claim_o = !(f_isa && pri_alias);
      end else if (pri_mem_i && pri_mem_win_hit_i) begin
         pri_claim_o = 1'b1;
      end
   end

   // secondary decode of the same ranges
   assign sec_vga_mem = sec_mem_i && (sec_addr_i >= `BCU_VGA_MEM_LO)
      && (sec_addr_i <= `BCU_VGA_MEM_HI);
   assign sec_vga_io = sec_io_i
      && (sec_addr_i[31:16] == `BCU_IO_64K_UPPER)
      && (((sec_addr_i[9:0] >= `BCU_VGA_IO_A_LO)
           && (sec_addr_i[9:0] <= `BCU_VGA_IO_A_HI))
          || ((sec_addr_i[9:0] >= `BCU_VGA_IO_B_LO)
              && (sec_addr_i[9:0] <= `BCU_VGA_IO_B_HI)));
   assign sec_alias = (sec_addr_i[31:16] == `BCU_IO_64K_UPPER)
      && (sec_addr_i[9:0] >= `BCU_ISA_ALIAS_LO);

   // upstream claim: outside the windows, or an aliased I/O address
   always_comb begin
      sec_claim_o = 1'b0;
      if (vga_ok && (sec_vga_mem || sec_vga_io)) begin
         sec_claim_o = 1'b0;
      end else if (sec_io_i) begin
         sec_claim_o = !pri_io_win_hit_i || (f_isa && sec_alias);
      end else if (sec_mem_i) begin
         sec_claim_o = !pri_mem_win_hit_i;
      end
   end

   // secondary reset pin tracks a lane-2 write of bit 22
   property p_sec_reset_pin;
      @(posedge core_clk_i) disable iff (!rst_n)
      (cfg_wr_i && cfg_hit && !cfg_byte_en_n_i[`BCU_LANE_MID])
         |=> sec_bus_reset_n_o == !$past(cfg_wdata_i[`BCU_BIT_SEC_RESET]);
   endproperty
   a_sec_reset_pin: assert property (p_sec_reset_pin)
      else $error("secondary reset pin does not follow bit 22");

   // fast back-to-back and reserved bits read zero
   property p_ro_bits_zero;
      @(posedge core_clk_i) disable iff (!rst_n)
      (cfg_rd_i && cfg_hit) |=> !cfg_rdata_o[`BCU_BIT_SEC_FB2B]
         && !cfg_rdata_o[`BCU_BIT_RSVD];
   endproperty
   a_ro_bits_zero: assert property (p_ro_bits_zero)
      else $error("read-only zero bit read as one");

   // control word is clear right after reset release
   property p_ctrl_reset;
      @(posedge core_clk_i) $rose(rst_n) |-> ctrl_q == `BCU_CTRL_RESET;
   endproperty
   a_ctrl_reset: assert property (p_ctrl_reset)
      else $error("control word not clear after reset");

   // mode 0 read abort returns all ones with TRDY
   property p_ma_mode0;
      @(posedge core_clk_i) disable iff (!rst_n)
      (ma_event_i && !ma_posted_i && ma_read_i && !f_ma_mode)
         |=> ma_trdy_o && !ma_target_abort_o
         && ma_rdata_o == `BCU_MA_READ_DATA;
   endproperty
   a_ma_mode0: assert property (p_ma_mode0)
      else $error("mode 0 master abort not completed with ones");

   // mode 1 posted abort raises the system error pin
   property p_ma_mode1_serr;
      @(posedge core_clk_i) disable iff (!rst_n)
      (ma_event_i && ma_posted_i && f_ma_mode && cmd_system_error_forward_enable_i)
         |=> !primary_system_error_pin_oe_n_o && !ma_target_abort_o;
   endproperty
   a_ma_mode1_serr: assert property (p_ma_mode1_serr)
      else $error("posted abort did not raise system error");

   // forwarded secondary system error reaches the primary pin
   property p_serr_forward;
      @(posedge core_clk_i) disable iff (!rst_n)
      (!secondary_system_error_pin_n_i && f_serr && cmd_system_error_forward_enable_i)[*3]
         |=> !primary_system_error_pin_oe_n_o;
   endproperty
   a_serr_forward: assert property (p_serr_forward)
      else $error("secondary system error not forwarded");

   // parity pin only with response enabled
   property p_perr_pin;
      @(posedge core_clk_i) disable iff (!rst_n)
      sec_data_perr_i |=> secondary_parity_error_pin_oe_n_o == !$past(f_perr);
   endproperty
   a_perr_pin: assert property (p_perr_pin)
      else $error("parity pin disagrees with parity response");

   // claimed video ranges are never taken upstream
   property p_vga_claim;
      @(posedge core_clk_i) disable iff (!rst_n)
      vga_ok |-> (pri_vga_mem ? pri_claim_o : 1'b1)
         && !((sec_vga_mem || sec_vga_io) && sec_claim_o);
   endproperty
   a_vga_claim: assert property (p_vga_claim)
      else $error("video range claimed on the wrong side");

   // filtered aliases are not forwarded downstream
   property p_alias_filter;
      @(posedge core_clk_i) disable iff (!rst_n)
      (f_isa && pri_io_i && pri_alias && !(vga_ok && pri_vga_io))
         |-> !pri_claim_o;
   endproperty
   a_alias_filter: assert property (p_alias_filter)
      else $error("aliased I/O forwarded downstream");

endmodule // bcu_bridge_control

/* File: hdl/bcu_regs.svh */
`ifndef BCU_REGS_SVH
`define BCU_REGS_SVH

// configuration offset of the bridge control word
`define BCU_OFS_BRIDGE_CTRL 8'h3C
// field positions in the bridge control word
`define BCU_BIT_PRI_TMO 24
`define BCU_BIT_SEC_FB2B 23
`define BCU_BIT_SEC_RESET 22
`define BCU_BIT_MA_MODE 21
`define BCU_BIT_RSVD 20
`define BCU_BIT_VGA 19
`define BCU_BIT_ISA 18
`define BCU_BIT_SERR_FWD 17
`define BCU_BIT_PERR_RESP 16
// byte lanes owned by this block
`define BCU_LANE_HI 3
`define BCU_LANE_MID 2
// reset value and writable bits
`define BCU_CTRL_RESET 32'h0000_0000
`define BCU_CTRL_WMASK 32'h016F_0000
// data returned for a master-aborted read
`define BCU_MA_READ_DATA 32'hFFFF_FFFF
// legacy video ranges
`define BCU_VGA_MEM_LO 32'h000A_0000
`define BCU_VGA_MEM_HI 32'h000B_FFFF
`define BCU_VGA_IO_A_LO 10'h3B0
`define BCU_VGA_IO_A_HI 10'h3BB
`define BCU_VGA_IO_B_LO 10'h0C0
`define BCU_VGA_IO_B_HI 10'h3DF
// first 64KB of I/O space and the aliased upper 768 bytes of each 1KB
`define BCU_IO_64K_UPPER 16'h0000
`define BCU_ISA_ALIAS_LO 10'h100
// retry timeout limits in PCI clocks
`define BCU_TMO_LONG_CLKS 32768
`define BCU_TMO_SHORT_CLKS 1024

`endif

/* File: hdl/bcu_pkg.sv */
package bcu_pkg;

   // retry timer states
   typedef enum logic {
      BCU_TMR_IDLE,
      BCU_TMR_COUNT
   } bcu_tmr_state_t;

endpackage

/* File: hdl/bcu_retry_timer.sv */
`timescale 1ns/1ps
`include "bcu_regs.svh"

module bcu_retry_timer
   import bcu_pkg::*;
#(
   parameter int unsigned LONG_CLKS = `BCU_TMO_LONG_CLKS,
   parameter int unsigned SHORT_CLKS = `BCU_TMO_SHORT_CLKS,
   parameter int unsigned CW = 16
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic clear_i,
   input wire logic short_sel_i,
   input wire logic head_valid_i,
   input wire logic retry_i,
   output logic discard_o
);

   bcu_tmr_state_t state_q;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] limit_q;
   logic discard_q;
   logic head_prev_q;

   // head flag one clock back; a count starts only on a new head
   // so a repeated transaction is never counted again and discarded
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         head_prev_q <= 1'b0;
      end else begin
         head_prev_q <= head_valid_i;
      end
   end

   // waits for a repeat once the completion heads the queue
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= BCU_TMR_IDLE;
         cnt_q <= '0;
         limit_q <= '0;
         discard_q <= 1'b0;
      end else begin
         discard_q <= 1'b0;
         if (clear_i) begin
            state_q <= BCU_TMR_IDLE;
         end else begin
            case (state_q)
               BCU_TMR_IDLE: begin
                  if (head_valid_i && !head_prev_q && !retry_i) begin
                     state_q <= BCU_TMR_COUNT;
                     cnt_q <= '0;
                     limit_q <= short_sel_i ? CW'(SHORT_CLKS - 1)
                                            : CW'(LONG_CLKS - 1);
                  end
               end
               BCU_TMR_COUNT: begin
                  if (retry_i || !head_valid_i) begin
                     state_q <= BCU_TMR_IDLE;
                  end else if (cnt_q == limit_q) begin
                     discard_q <= 1'b1;
                     state_q <= BCU_TMR_IDLE;
                  end else begin
                     cnt_q <= cnt_q + 1'b1;
                  end
               end
               default: state_q <= BCU_TMR_IDLE;
            endcase
         end
      end
   end

   assign discard_o = discard_q;

   // a discard only ends a full count
   property p_tmr_discard_at_limit;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      $rose(discard_q) |-> $past(state_q == BCU_TMR_COUNT)
         && $past(cnt_q) == $past(limit_q) && !$past(retry_i);
   endproperty
   a_tmr_discard_at_limit: assert property (p_tmr_discard_at_limit)
      else $error("retry timer discarded before its limit");

   // a repeat ends the wait without a discard
   property p_tmr_retry_stops;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (state_q == BCU_TMR_COUNT && retry_i && !clear_i)
         |=> state_q == BCU_TMR_IDLE && !discard_q;
   endproperty
   a_tmr_retry_stops: assert property (p_tmr_retry_stops)
      else $error("repeated transaction still discarded");

endmodule // bcu_retry_timer

/* File: tb/bcu_sec_agent.sv */
`timescale 1ns/1ps

module bcu_sec_agent (
   input wire logic core_clk_i,
   input wire logic raise_serr_i,
   output logic secondary_system_error_pin_n_o
);
   logic drive_q = 1'b0;

   // agent pulls the shared error line low just after an edge
   always @(posedge core_clk_i) begin
      drive_q <= raise_serr_i;
   end

   // open-drain line: released means pulled up, never the last value
   assign secondary_system_error_pin_n_o = drive_q ? 1'b0 : 1'b1;
endmodule // bcu_sec_agent

/* File: tb/tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
   total_checks++; \
   if ((g) !== (e)) begin \
      num_errors++; \
      $display("unexpected %s expected %h seen %h", nm, e, g); \
   end \
end

module tb;
   import bcu_pkg::*;
   localparam int LIM = 64;
   localparam int SLIM = 1024;
   int num_errors = 0;
   int total_checks = 0;
   int n;
   logic core_clk_i, reset_n_i, cfg_wr_i, cfg_rd_i, raise;
   logic [7:0] cfg_addr_i;
   logic [3:0] cfg_byte_en_n_i;
   logic [31:0] cfg_wdata_i, cfg_rdata_o, ma_rdata_o, pri_addr_i, sec_addr_i;
   logic cmd_io_space_en_i, cmd_mem_space_en_i, cmd_system_error_forward_enable_i;
   logic dt_head_valid_i, dt_retry_i, dt_discard_o;
   logic ma_event_i, ma_posted_i, ma_read_i, ma_trdy_o, ma_target_abort_o;
   logic pri_io_i, pri_mem_i, pri_io_win_hit_i, pri_mem_win_hit_i;
   logic pri_claim_o, sec_io_i, sec_mem_i, sec_claim_o;
   logic sec_data_perr_i, sec_addr_perr_i, sec_bridge_master_i;
   logic data_parity_reported_set_o, secondary_system_error_pin_n_i;
   logic primary_system_error_pin_o, primary_system_error_pin_oe_n_o;
   logic secondary_parity_error_pin_o, secondary_parity_error_pin_oe_n_o;
   logic sec_bus_reset_n_o, sec_logic_reset_o;

   bcu_bridge_control #(.TMO_LONG_CLKS(LIM)) uut (
      .core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
      .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i),
      .cfg_byte_en_n_i(cfg_byte_en_n_i), .cfg_wdata_i(cfg_wdata_i),
      .cfg_rdata_o(cfg_rdata_o), .cmd_io_space_en_i(cmd_io_space_en_i),
      .cmd_mem_space_en_i(cmd_mem_space_en_i), .cmd_system_error_forward_enable_i(cmd_system_error_forward_enable_i),
      .dt_head_valid_i(dt_head_valid_i), .dt_retry_i(dt_retry_i),
      .dt_discard_o(dt_discard_o), .ma_event_i(ma_event_i),
      .ma_posted_i(ma_posted_i), .ma_read_i(ma_read_i), .ma_trdy_o(ma_trdy_o),
      .ma_target_abort_o(ma_target_abort_o), .ma_rdata_o(ma_rdata_o),
      .pri_addr_i(pri_addr_i), .pri_io_i(pri_io_i), .pri_mem_i(pri_mem_i),
      .pri_io_win_hit_i(pri_io_win_hit_i),
      .pri_mem_win_hit_i(pri_mem_win_hit_i), .pri_claim_o(pri_claim_o),
      .sec_addr_i(sec_addr_i), .sec_io_i(sec_io_i), .sec_mem_i(sec_mem_i),
      .sec_claim_o(sec_claim_o), .sec_data_perr_i(sec_data_perr_i),
      .sec_addr_perr_i(sec_addr_perr_i),
      .sec_bridge_master_i(sec_bridge_master_i),
      .data_parity_reported_set_o(data_parity_reported_set_o),
      .secondary_system_error_pin_n_i(secondary_system_error_pin_n_i),
      .primary_system_error_pin_o(primary_system_error_pin_o),
      .primary_system_error_pin_oe_n_o(primary_system_error_pin_oe_n_o),
      .secondary_parity_error_pin_o(secondary_parity_error_pin_o),
      .secondary_parity_error_pin_oe_n_o(secondary_parity_error_pin_oe_n_o),
      .sec_bus_reset_n_o(sec_bus_reset_n_o),
      .sec_logic_reset_o(sec_logic_reset_o)
   );

   bcu_sec_agent agent (
      .core_clk_i(core_clk_i), .raise_serr_i(raise),
      .secondary_system_error_pin_n_o(secondary_system_error_pin_n_i)
   );

   // 25 MHz clock
   initial begin
      core_clk_i = 1'b0;
      forever #20 core_clk_i = ~core_clk_i;
   end

   // inputs change a fixed 2 ns after each rising edge
   task tick();
      @(posedge core_clk_i);
      #2;
   endtask

   task wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      cfg_addr_i = a;
      cfg_byte_en_n_i = be;
      cfg_wdata_i = d;
      cfg_wr_i = 1'b1;
      tick();
      cfg_wr_i = 1'b0;
      tick();
   endtask

   task rd(input logic [7:0] a, input logic [31:0] e);
      cfg_addr_i = a;
      cfg_rd_i = 1'b1;
      tick();
      cfg_rd_i = 1'b0;
      `CHK("cfg_rdata_o", e, cfg_rdata_o)
      tick();
   endtask

   task ctl(input logic [31:0] d);
      wr(8'h3C, 4'b0011, d);
   endtask

   // count edges until a discard pulse, -1 when none arrives
   task wait_dc(input int max, output int cnt);
      cnt = -1;
      for (int i = 1; i <= max && cnt < 0; i++) begin
         tick();
         if (dt_discard_o === 1'b1) cnt = i;
      end
   endtask

   task run_tmr(input int lim);
      int c;
      dt_head_valid_i = 1'b1;
      wait_dc(lim + 10, c);
      `CHK("discard delay", 1'b1, (c >= lim && c <= lim + 2))
      dt_head_valid_i = 1'b0;
      tick();
   endtask

   task ma(input logic posted, input logic rdq);
      tick(); // previous pulse ends at an edge first
      ma_event_i = 1'b1;
      ma_posted_i = posted;
      ma_read_i = rdq;
      tick();
      ma_event_i = 1'b0;
   endtask

   task dec(input logic io, mem, wio, wmem, input logic [31:0] a, e);
      tick();
      pri_io_i = io;
      pri_mem_i = mem;
      pri_io_win_hit_i = wio;
      pri_mem_win_hit_i = wmem;
      pri_addr_i = a;
      #1;
      `CHK("pri_claim_o", e, pri_claim_o)
   endtask

   task sdec(input logic io, mem, input logic [31:0] a, e);
      tick();
      sec_io_i = io;
      sec_mem_i = mem;
      sec_addr_i = a;
      #1;
      `CHK("sec_claim_o", e, sec_claim_o)
   endtask

   task perr(input logic dat, input logic adr);
      tick(); // previous pulse ends at an edge first
      sec_data_perr_i = dat;
      sec_addr_perr_i = adr;
      tick();
      sec_data_perr_i = 1'b0;
      sec_addr_perr_i = 1'b0;
   endtask

   task finish_test();
      if (num_errors == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // watchdog well beyond the expected run length
   initial begin
      #(40 * 10000);
      num_errors++;
      finish_test();
   end

   // main sequence
   initial begin
      {reset_n_i, cfg_wr_i, cfg_rd_i, raise, cfg_addr_i, cfg_byte_en_n_i} = 0;
      {cfg_wdata_i, pri_addr_i, sec_addr_i, cmd_io_space_en_i} = 0;
      {cmd_mem_space_en_i, cmd_system_error_forward_enable_i, dt_head_valid_i, dt_retry_i} = 0;
      {ma_event_i, ma_posted_i, ma_read_i, pri_io_i, pri_mem_i} = 0;
      {pri_io_win_hit_i, pri_mem_win_hit_i, sec_io_i, sec_mem_i} = 0;
      {sec_data_perr_i, sec_addr_perr_i, sec_bridge_master_i} = 0;
      repeat (12) tick();
      reset_n_i = 1'b1;
      repeat (3) tick();
      rd(8'h3C, 32'h0000_0000);
      `CHK("sec_bus_reset_n_o", 1'b1, sec_bus_reset_n_o)
      wr(8'h3C, 4'b0000, 32'hFFFF_FFFF);
      `CHK("sec_bus_reset_n_o", 1'b0, sec_bus_reset_n_o)
      `CHK("sec_logic_reset_o", 1'b1, sec_logic_reset_o)
      rd(8'h3C, 32'h016F_0000);
      wr(8'h3C, 4'b1111, 32'h0000_0000);
      rd(8'h3C, 32'h016F_0000);
      wr(8'h40, 4'b0000, 32'hFFFF_FFFF);
      rd(8'h40, 32'h0000_0000);
      ctl(32'h0000_0000);
      `CHK("sec_bus_reset_n_o", 1'b1, sec_bus_reset_n_o)
      `CHK("sec_logic_reset_o", 1'b0, sec_logic_reset_o)
      // retry limits, start condition, repeats and secondary reset
      run_tmr(LIM);
      wait_dc(LIM + 10, n);
      `CHK("idle discard", -1, n)
      dt_head_valid_i = 1'b1;
      repeat (10) tick();
      dt_retry_i = 1'b1;
      tick();
      dt_retry_i = 1'b0;
      wait_dc(LIM + 10, n);
      `CHK("retried discard", -1, n)
      dt_head_valid_i = 1'b0;
      tick();
      dt_head_valid_i = 1'b1;
      repeat (10) tick();
      ctl(32'h0040_0000);
      wait_dc(LIM + 10, n);
      `CHK("reset discard", -1, n)
      dt_head_valid_i = 1'b0;
      ctl(32'h0100_0000);
      run_tmr(SLIM);
      // master abort in both modes
      cmd_system_error_forward_enable_i = 1'b1;
      ctl(32'h0000_0000);
      ma(1'b0, 1'b1);
      `CHK("ma_trdy_o", 1'b1, ma_trdy_o)
      `CHK("ma_target_abort_o", 1'b0, ma_target_abort_o)
      `CHK("ma_rdata_o", 32'hFFFF_FFFF, ma_rdata_o)
      ma(1'b1, 1'b0);
      `CHK("serr oe_n", 1'b1, primary_system_error_pin_oe_n_o)
      ctl(32'h0020_0000);
      ma(1'b0, 1'b1);
      `CHK("ma_target_abort_o", 1'b1, ma_target_abort_o)
      `CHK("ma_trdy_o", 1'b0, ma_trdy_o)
      `CHK("ma_rdata_o", 32'h0000_0000, ma_rdata_o)
      ma(1'b1, 1'b0);
      `CHK("serr oe_n", 1'b0, primary_system_error_pin_oe_n_o)
      // primary and secondary decode
      cmd_io_space_en_i = 1'b1;
      cmd_mem_space_en_i = 1'b1;
      ctl(32'h0000_0000);
      dec(1, 0, 0, 0, 32'h0000_03B0, 1'b0);
      dec(1, 0, 1, 0, 32'h0000_03B0, 1'b1);
      dec(0, 1, 0, 0, 32'h000A_0000, 1'b0);
      dec(1, 0, 1, 0, 32'h0000_0100, 1'b1);
      ctl(32'h0004_0000);
      dec(1, 0, 1, 0, 32'h0000_0100, 1'b0);
      dec(1, 0, 1, 0, 32'h0000_03B0, 1'b0);
      dec(1, 0, 1, 0, 32'h0000_0050, 1'b1);
      dec(1, 0, 1, 0, 32'h0001_0100, 1'b1);
      dec(0, 0, 1, 0, 32'h0000_0000, 1'b0);
      sdec(1, 0, 32'h0000_0100, 1'b1);
      sdec(1, 0, 32'h0000_0050, 1'b0);
      ctl(32'h000C_0000);
      dec(0, 1, 0, 0, 32'h000A_0000, 1'b1);
      ctl(32'h0008_0000);
      dec(0, 1, 0, 0, 32'h000B_FFFF, 1'b1);
      dec(0, 1, 0, 0, 32'h000C_0000, 1'b0);
      dec(1, 0, 0, 0, 32'h0000_03BB, 1'b1);
      dec(1, 0, 0, 0, 32'h0000_00BF, 1'b0);
      dec(1, 0, 0, 0, 32'h0000_00C0, 1'b1);
      dec(1, 0, 0, 0, 32'h0000_03DF, 1'b1);
      dec(1, 0, 0, 0, 32'h0000_03E0, 1'b0);
      dec(1, 0, 0, 0, 32'h0000_7BB0, 1'b1);
      sdec(0, 1, 32'h000A_0000, 1'b0);
      sdec(1, 0, 32'h0000_03B0, 1'b0);
      cmd_io_space_en_i = 1'b0;
      dec(0, 1, 0, 0, 32'h000A_0000, 1'b0);
      cmd_io_space_en_i = 1'b1;
      // system error forwarding from the secondary line
      ctl(32'h0002_0000);
      raise = 1'b1;
      repeat (6) tick();
      `CHK("serr oe_n", 1'b0, primary_system_error_pin_oe_n_o)
      `CHK("serr pin", 1'b0, primary_system_error_pin_o)
      raise = 1'b0;
      repeat (6) tick();
      `CHK("serr oe_n", 1'b1, primary_system_error_pin_oe_n_o)
      ctl(32'h0000_0000);
      raise = 1'b1;
      repeat (6) tick();
      `CHK("serr oe_n", 1'b1, primary_system_error_pin_oe_n_o)
      raise = 1'b0;
      repeat (6) tick();
      // parity response
      sec_bridge_master_i = 1'b1;
      perr(1'b1, 1'b0);
      `CHK("perr oe_n", 1'b1, secondary_parity_error_pin_oe_n_o)
      `CHK("dpr set", 1'b0, data_parity_reported_set_o)
      perr(1'b0, 1'b1);
      `CHK("serr oe_n", 1'b1, primary_system_error_pin_oe_n_o)
      ctl(32'h0001_0000);
      perr(1'b1, 1'b0);
      `CHK("perr oe_n", 1'b0, secondary_parity_error_pin_oe_n_o)
      `CHK("perr pin", 1'b0, secondary_parity_error_pin_o)
      `CHK("dpr set", 1'b1, data_parity_reported_set_o)
      tick();
      perr(1'b0, 1'b1);
      `CHK("serr oe_n", 1'b0, primary_system_error_pin_oe_n_o)
      // parity error on a cycle the bridge did not master
      sec_bridge_master_i = 1'b0;
      perr(1'b1, 1'b0);
      `CHK("perr oe_n", 1'b0, secondary_parity_error_pin_oe_n_o)
      `CHK("dpr set", 1'b0, data_parity_reported_set_o)
      repeat (3) tick();
      finish_test();
   end
endmodule // tb
